// ===== design/i2sap_defines.vh
/*
 * constants for the stereo serial audio transmit port
 * assumes the core clock runs at 40 MHz
 */
`ifndef I2SAP_DEFINES_VH
`define I2SAP_DEFINES_VH

// ************************************************
// word and frame layout, core clock rate
// ************************************************
`define I2SAP_WORD_BITS 16
`define I2SAP_FRAME_BITS 32
`define I2SAP_FRAME_RATE_HZ 48000
`define I2SAP_CLK_HZ 40000000

// ************************************************
// fractional divider defaults and slave bit clock limit
// ************************************************
// half bit clock = 3.072 MHz toggle rate; n/m = 3072000/40000000 = 48/625
`define I2SAP_DIV_N 16'h0030
`define I2SAP_DIV_M 16'h0271
`define I2SAP_SLAVE_MAX_SCK_HZ 3072000

`endif

// ===== design/i2sap_buf2.v
/*
 * two-entry buffer with valid/ready on both sides
 * assumes source and sink share the one clock
 */
`timescale 1ns/10ps
`include "i2sap_defines.vh"

module i2sap_buf2 #(
    parameter WIDTH = 32
) (
    input wire clock, // core clock
    input wire rst, // sync reset, high
    input wire [WIDTH-1:0] in_data, // word in
    input wire in_valid, // word in valid
    output wire in_ready, // room for a word
    output wire [WIDTH-1:0] out_data, // oldest word
    output wire out_valid, // word available
    input wire out_ready // sink takes word
);

    reg [WIDTH-1:0] mem [0:1];
    reg rd_ptr;
    reg wr_ptr;
    reg [1:0] count;
    wire push;
    wire pop;

    assign in_ready = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always @(posedge clock) begin
        if (rst) begin
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            if (push & ~pop) begin
                count <= count + 2'h1;
            end else if (pop & ~push) begin
                count <= count - 2'h1;
            end
        end
    end

    always @(posedge clock) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

endmodule

// ===== design/i2sap_port.v
/*
 * stereo serial audio transmit port, master or slave clocking
 * assumes stereo samples arrive on the core clock with valid/ready;
 * pads of bit clock and word select are resolved outside from the enables
 */
// What this block does
// - selectable master or slave, one port
// - master drives clocks; data always driven
// - 16-bit words, msb first, standard alignment
// - msb one bit after select edge, falling
// - left while select low, right high
// - master: 48 kHz frames at the default n/m, 32 bits each
// - master bit clock from n/m divider
`timescale 1ns/10ps
`include "i2sap_defines.vh"

module i2sap_port #(
    parameter WORD_BITS = `I2SAP_WORD_BITS,
    parameter [15:0] DIV_N = `I2SAP_DIV_N,
    parameter [15:0] DIV_M = `I2SAP_DIV_M
) (
    input wire clock, // core clock 40 MHz
    input wire rst, // sync reset, high
    input wire master_mode, // 1 master, 0 slave
    input wire [15:0] div_n, // divider numerator
    input wire [15:0] div_m, // divider denominator
    input wire [2*WORD_BITS-1:0] sample_data, // {left, right}
    input wire sample_valid, // sample offered
    output reg sample_ready, // sample taken
    input wire sck_in, // bit clock pad in
    output reg sck_out, // bit clock pad out
    output reg sck_oe, // bit clock drive enable
    input wire ws_in, // word select pad in
    output reg ws_out, // word select pad out
    output reg ws_oe, // word select drive enable
    output reg sdo, // serial data out
    output reg underrun // last frame had no sample
);

    // ************************************************
    // buffer in the sample path
    // ************************************************
    wire [2*WORD_BITS-1:0] buf_data;
    wire buf_valid;
    wire buf_in_ready;
    reg buf_pop;

    i2sap_buf2 #(
        .WIDTH(2*WORD_BITS)
    ) u_buf (
        .clock(clock),
        .rst(rst),
        .in_data(sample_data),
        .in_valid(sample_valid),
        .in_ready(buf_in_ready),
        .out_data(buf_data),
        .out_valid(buf_valid),
        .out_ready(buf_pop)
    );

    // registered ready lags a cycle, so it is only a hint
    always @(posedge clock) begin
        if (rst) begin
            sample_ready <= 1'b0;
        end else begin
            sample_ready <= sample_valid & buf_in_ready;
        end
    end

    // ************************************************
    // fractional divider, master bit clock
    // ************************************************
    // n must be nonzero and below m, or the bit clock stops or saturates
    reg [16:0] acc;
    reg tick;
    wire [16:0] acc_sum;
    // zero denominator would lock the divider; fall back to defaults
    wire [15:0] use_n = (div_m == 16'h0000) ? DIV_N : div_n;
    wire [15:0] use_m = (div_m == 16'h0000) ? DIV_M : div_m;
    assign acc_sum = acc + {1'b0, use_n};

    always @(posedge clock) begin
        if (rst) begin
            acc <= 17'h00000;
            tick <= 1'b0;
        end else if (acc_sum >= {1'b0, use_m}) begin
            acc <= acc_sum - {1'b0, use_m};
            tick <= 1'b1;
        end else begin
            acc <= acc_sum;
            tick <= 1'b0;
        end
    end

    // ************************************************
    // slave pin synchronisers, three stages
    // ************************************************
    // sync plus edge detect cost about four core cycles, so a slave
    // bit clock must stay well under an eighth of the core clock
    reg [2:0] sck_sync;
    reg [2:0] ws_sync;
    reg sck_state;
    reg ws_state;

    always @(posedge clock) begin
        if (rst) begin
            sck_sync <= 3'h0;
            ws_sync <= 3'h0;
            sck_state <= 1'b0;
            ws_state <= 1'b0;
        end else begin
            sck_sync <= {sck_sync[1:0], sck_in};
            ws_sync <= {ws_sync[1:0], ws_in};
            if (sck_sync[1] == sck_sync[2]) begin
                sck_state <= sck_sync[2];
            end
            if (ws_sync[1] == ws_sync[2]) begin
                ws_state <= ws_sync[2];
            end
        end
    end

    // ************************************************
    // bit clock edges for either mode
    // ************************************************
    reg sck_state_d;
    wire slv_fall = sck_state_d & ~sck_state;
    wire mst_fall = master_mode & tick & sck_out;
    wire fall = master_mode ? mst_fall : slv_fall;
    reg [4:0] bit_cnt;
    reg ws_prev;
    reg [WORD_BITS-1:0] shreg;
    reg [WORD_BITS-1:0] right_hold;
    reg start_pend;

    always @(posedge clock) begin
        if (rst) begin
            sck_state_d <= 1'b0;
            sck_out <= 1'b0;
            sck_oe <= 1'b0;
            ws_oe <= 1'b0;
        end else begin
            sck_state_d <= sck_state;
            sck_oe <= master_mode;
            ws_oe <= master_mode;
            if (master_mode & tick) begin
                sck_out <= ~sck_out;
            end else if (~master_mode) begin
                sck_out <= 1'b0;
            end
        end
    end

    // ************************************************
    // frame sequencing and shifting
    // ************************************************
    // ws in slave mode is sampled at the falling edge of the bit clock;
    // a change seen there is the select edge, data msb follows next fall
    // master looks at the select value this fall produces, not the old one;
    // waiting for the registered value would put the msb a bit late
    wire next_ws_out;
    assign next_ws_out = (bit_cnt == 5'h0f) ? 1'b1 : ((bit_cnt == 5'h1f) ? 1'b0 : ws_out);
    wire ws_now = master_mode ? next_ws_out : ws_state;
    wire [WORD_BITS-1:0] zero_word = {WORD_BITS{1'b0}};

    always @(posedge clock) begin
        if (rst) begin
            bit_cnt <= 5'h00;
            ws_out <= 1'b0;
            ws_prev <= 1'b0;
            shreg <= zero_word;
            right_hold <= zero_word;
            start_pend <= 1'b0;
            sdo <= 1'b0;
            buf_pop <= 1'b0;
            underrun <= 1'b0;
        end else begin
            buf_pop <= 1'b0;
            if (fall) begin
                if (master_mode) begin
                    bit_cnt <= bit_cnt + 5'h01;
                    if (bit_cnt == 5'h0f) begin
                        ws_out <= 1'b1;
                    end else if (bit_cnt == 5'h1f) begin
                        ws_out <= 1'b0;
                    end
                end
                ws_prev <= ws_now;
                if (start_pend) begin
                    start_pend <= 1'b0;
                    sdo <= shreg[WORD_BITS-1];
                    shreg <= {shreg[WORD_BITS-2:0], 1'b0};
                end else begin
                    sdo <= shreg[WORD_BITS-1];
                    shreg <= {shreg[WORD_BITS-2:0], 1'b0};
                end
                if (ws_now != ws_prev) begin
                    start_pend <= 1'b1;
                    if (~ws_now) begin
                        // left word: fetch a fresh stereo sample
                        if (buf_valid) begin
                            shreg <= buf_data[2*WORD_BITS-1:WORD_BITS];
                            right_hold <= buf_data[WORD_BITS-1:0];
                            buf_pop <= 1'b1;
                            underrun <= 1'b0;
                        end else begin
                            shreg <= zero_word;
                            right_hold <= zero_word;
                            underrun <= 1'b1;
                        end
                    end else begin
                        shreg <= right_hold;
                    end
                end
            end
        end
    end

endmodule

// ===== bench/i2sap_port_sva.sv
/* checker for the serial audio port
   sees only the ports and divider parameters of i2sap_port, bound at the foot */
`timescale 1ns/10ps
module i2sap_port_chk #(
    parameter [15:0] DIV_N = 16'h0030,
    parameter [15:0] DIV_M = 16'h0271
) (
    input wire clock, // clk
    input wire rst, // reset
    input wire master_mode, // mode
    input wire [15:0] div_n, // n
    input wire [15:0] div_m, // m
    input wire sample_valid, // offer
    input wire sample_ready, // ack
    input wire sck_in, // pad
    input wire sck_out, // clk out
    input wire sck_oe, // clk oe
    input wire ws_out, // ws out
    input wire ws_oe, // ws oe
    input wire sdo // data
);
    reg [15:0] hp;
    reg [5:0] nb;
    reg ts;
    reg wseen;
    wire [15:0] dm = (div_m == 16'h0) ? DIV_M : div_m;
    wire [15:0] dn = (div_m == 16'h0) ? DIV_N : div_n;
    wire [15:0] q = dm / dn;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // ****
    // first toggle and first select edge follow reset, so they are skipped
    // ****
    always @(posedge clock) begin
        if (rst) begin
            hp <= 16'h0;
            nb <= 6'h0;
            ts <= 1'b0;
            wseen <= 1'b0;
        end else begin
            hp <= $changed(sck_out) ? 16'h1 : hp + 16'h1;
            ts <= ts | $changed(sck_out);
            nb <= $changed(ws_out) ? 6'h0 : nb + {5'h0, $rose(sck_out)};
            wseen <= wseen | $changed(ws_out);
        end
    end
    sequence ws_edge_s;
        master_mode && $changed(ws_out);
    endsequence
    sequence slave_held_s;
        !master_mode ##1 !master_mode;
    endsequence
    chk_oe_master: assert property ($stable(master_mode) |=> sck_oe == master_mode && ws_oe == master_mode)
        else $error("enable not following mode");
    chk_oe_slave: assert property (slave_held_s |-> !sck_oe && !ws_oe)
        else $error("slave drives clocks");
    chk_sdo_fall: assert property (master_mode && sck_oe && $changed(sdo) |-> !sck_out)
        else $error("data moved while clock high");
    chk_ws_fall: assert property (master_mode && sck_oe && $changed(ws_out) |-> !sck_out)
        else $error("select moved while clock high");
    chk_word_bits: assert property (ws_edge_s |-> !wseen || nb == 6'h10)
        else $error("word not 16 bit clocks");
    chk_sck_rate: assert property (master_mode && ts && $changed(sck_out) |-> hp == q || hp == q + 16'h1)
        else $error("bit clock rate off");
    chk_ready_cause: assert property (sample_ready |-> $past(sample_valid))
        else $error("ack without offer");
    chk_slave_sdo: assert property (!master_mode && $changed(sdo) |-> !sck_in)
        else $error("slave data moved while clock high");
endmodule
bind i2sap_port i2sap_port_chk #(.DIV_N(DIV_N), .DIV_M(DIV_M)) i_chk (.clock(clock), .rst(rst),
    .master_mode(master_mode), .div_n(div_n), .div_m(div_m), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe),
    .ws_out(ws_out), .ws_oe(ws_oe), .sdo(sdo));

// ===== bench/i2sap_codec.sv
/* far-side codec model: captures words, makes slave clocks
   assumes the bench resolves the pads from the enables */
`timescale 1ns/10ps
module i2sap_codec (
    input wire run, // make clocks
    input wire sck, // pad clock
    input wire ws, // pad select
    input wire sdo, // data
    output reg sck_m, // clock drive
    output reg ws_m, // select drive
    output reg [15:0] left, // last left
    output reg [15:0] right, // last right
    output reg [15:0] frames // frames seen
);
    reg [15:0] sh = 16'h0;
    reg ws_q = 1'b0;
    integer n = 0;
    initial begin
        sck_m = 1'b0;
        ws_m = 1'b0;
        left = 16'h0;
        right = 16'h0;
        frames = 16'h0;
    end
    // ****
    // 326 ns period, just under the top slave rate; still between runs
    // ****
    always begin
        if (run) begin
            #163 sck_m = 1'b1;
            #163 sck_m = 1'b0;
            n = n + 1;
            if (n == 16) begin
                n = 0;
                ws_m = ~ws_m;
            end
        end else
            #25;
    end
    always @(posedge sck) begin
        sh = {sh[14:0], sdo};
        if (ws != ws_q) begin
            if (ws_q) begin
                right = sh;
                frames = frames + 16'h1;
            end else
                left = sh;
        end
        ws_q = ws;
    end
endmodule

// ===== bench/i2sap_port_tb_top.sv
/* bench for the serial audio port
   assumes the codec model and the bound checker */
`timescale 1ns/10ps
module i2sap_port_tb_top;
    reg clock = 0, rst = 1, mode = 1, valid = 0, run = 0;
    reg [15:0] dn = 0, dm = 0;
    reg [31:0] data = 0;
    wire ready, sck_out, sck_oe, ws_out, ws_oe, sdo, underrun, sck_m, ws_m;
    wire [15:0] left, right, frames;
    wire sck = sck_oe ? sck_out : sck_m;
    wire ws = ws_oe ? ws_out : ws_m;
    integer mismatches = 0, compares = 0;
    always #12.5 clock = ~clock;
    i2sap_port i_dut (.clock(clock), .rst(rst), .master_mode(mode), .div_n(dn), .div_m(dm),
        .sample_data(data), .sample_valid(valid), .sample_ready(ready), .sck_in(sck),
        .sck_out(sck_out), .sck_oe(sck_oe), .ws_in(ws), .ws_out(ws_out), .ws_oe(ws_oe),
        .sdo(sdo), .underrun(underrun));
    i2sap_codec i_codec (.run(run), .sck(sck), .ws(ws), .sdo(sdo), .sck_m(sck_m),
        .ws_m(ws_m), .left(left), .right(right), .frames(frames));
    // ****
    // shared tasks
    // ****
    task report_and_stop;
        begin
            $display("compares %0d mismatches %0d", compares, mismatches);
            if (mismatches == 0 && compares > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    task cmp16(input [15:0] got, input [15:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("[FAIL] %0t got %h want %h", $time, got, exp);
            end
        end
    endtask
    task start(input m, input [15:0] n, input [15:0] d);
        begin
            @(negedge clock);
            rst = 1;
            run = 0;
            valid = 0;
            mode = m;
            dn = n;
            dm = d;
            repeat (8) @(negedge clock);
            rst = 0;
        end
    endtask
    task wait_frames(input integer k);
        integer t;
        integer f0;
        begin
            f0 = frames;
            t = 0;
            while (frames < f0 + k && t < 20000) begin
                @(negedge clock);
                t = t + 1;
            end
            if (t == 20000) begin
                mismatches = mismatches + 1;
                $display("[FAIL] %0t frames stalled", $time);
                report_and_stop;
            end
        end
    endtask
    // ****
    // scenarios
    // ****
    task play(input m, input [15:0] n, input [15:0] d, input [31:0] s);
        begin
            start(m, n, d);
            data = s;
            valid = 1;
            run = !m;
            wait_frames(3);
            cmp16(left, s[31:16]);
            cmp16(right, s[15:0]);
            cmp16({15'h0, underrun}, 16'h0);
        end
    endtask
    // slave with clocks still: two words fit, the rest refused, then drain to zeros
    task scen_fill;
        integer i, acks;
        begin
            start(0, 16'h0, 16'h0);
            acks = 0;
            data = 32'h1234_8765;
            valid = 1;
            for (i = 0; i < 20; i = i + 1) begin
                @(negedge clock);
                acks = acks + ready;
            end
            cmp16(acks[15:0], 16'h2);
            valid = 0;
            run = 1;
            wait_frames(3);
            cmp16(left, 16'h1234);
            cmp16(right, 16'h8765);
            wait_frames(2);
            cmp16(left, 16'h0);
            cmp16({15'h0, underrun}, 16'h1);
        end
    endtask
    initial begin
        play(1, 16'h0, 16'h0, 32'ha5c3_3c5a);
        play(1, 16'h1, 16'h10, 32'h8001_7ffe);
        play(0, 16'h0, 16'h0, 32'h0f0f_c3a5);
        scen_fill;
        report_and_stop;
    end
endmodule
